/* File: design/cbs_defines.svh */
// Offsets, field positions and reset values of the buffer status logic
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH
// ==========================================
// Register offsets
`define CBS_OFF_CTRLA 8'h00
`define CBS_OFF_CB_CLR 8'h04
`define CBS_OFF_CB_SET 8'h05
`define CBS_OFF_INT_CLR 8'h08
`define CBS_OFF_INT_EN 8'h09
`define CBS_OFF_INT_ST 8'h0A
`define CBS_OFF_STATUS 8'h0B
`define CBS_OFF_PERIOD 8'h1A
`define CBS_OFF_PER_BUF 8'h1B
`define CBS_OFF_CH_VAL 8'h20
`define CBS_OFF_CH_BUF 8'h30
// ==========================================
// Field positions
`define CBS_CTRLA_EN 1
`define CBS_CTRLA_MODE_LSB 2
`define CBS_CTRLA_CAP_LSB 4
`define CBS_CB_DIR 0
`define CBS_CB_LOCK 1
`define CBS_CB_SINGLE 2
`define CBS_CB_CMD_LSB 5
`define CBS_ST_STOP 0
`define CBS_ST_PAIR 1
`define CBS_ST_PERV 3
`define CBS_ST_CHV_LSB 4
`define CBS_INT_WRAP 0
`define CBS_INT_STOP 1
`define CBS_INT_UPD 2
`define CBS_INT_CAP 3
// ==========================================
// Reset values
`define CBS_RST_BYTE 8'h00
`define CBS_RST_STATUS 8'h01
`define CBS_RST_STOP 1'b1
`define CBS_RST_BIT 1'b0
`endif

/* File: design/cbs_pkg.sv */
// Types shared by the buffer status logic
package cbs_pkg;
	// ==========================================
	// Commands of the control field
	typedef enum logic [2:0] {
		CBS_CMD_NONE = 3'h0,
		CBS_CMD_RETRIGGER = 3'h1,
		CBS_CMD_STOP = 3'h2,
		CBS_CMD_UPDATE = 3'h3,
		CBS_CMD_COUNT_SYNC = 3'h4
	} cbs_cmd_type;
	// Counter width modes
	typedef enum logic [1:0] {
		CBS_MODE_16 = 2'h0,
		CBS_MODE_8 = 2'h1,
		CBS_MODE_32 = 2'h2
	} cbs_mode_type;
	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cbs_bus_req_type;
endpackage

/* File: design/cbs_top.sv */
// Buffer-valid, update-lock and run-status logic of one counter unit
`include "cbs_defines.svh"

module cbs_top import cbs_pkg::*; #(
	parameter int NUM_CH = 2,
	parameter bit IS_ODD = 1'b1
) (
	input wire logic clk, // Counter clock
	input wire logic rst, // Synchronous reset
	input wire cbs_bus_req_type bus_req, // Register access
	output logic [7:0] rd_data_q, // Read data, one cycle later
	input wire logic prescale_tick, // Prescaled counter tick
	input wire logic wrap_event, // Overflow or underflow pulse
	input wire logic [NUM_CH-1:0] capture_strobe, // Capture event
	input wire logic [7:0] capture_value, // Captured count
	input wire logic master_is_32bit, // Master counter mode
	output logic counter_run_q, // Counter may count
	output logic retrigger_q, // Restart pulse to core
	output logic read_sync_q, // Count sync pulse to core
	output logic count_dir_q, // Count direction
	output logic [7:0] period_q, // Active period
	output logic [NUM_CH-1:0][7:0] channel_value_q, // Active values
	output logic irq_q // Interrupt level
);
	// ==========================================
	// State
	logic en_q;
	logic en_prev_q;
	cbs_mode_type mode_q;
	logic [NUM_CH-1:0] cap_mode_q;
	logic lock_q;
	logic single_q;
	logic dir_q;
	cbs_cmd_type cmd_q;
	logic stop_q;
	logic stop_d;
	logic pair_q;
	logic [7:0] per_buf_q;
	logic per_valid_q;
	logic per_valid_d;
	logic [NUM_CH-1:0] ch_valid_q;
	logic [NUM_CH-1:0][7:0] ch_buf_q;
	logic [3:0] int_st_q;
	logic [3:0] int_st_d;
	logic [3:0] int_en_q;

	// ==========================================
	// Address decode
	wire wr = bus_req.wr;
	wire rd = bus_req.rd;
	wire [7:0] wd = bus_req.wdata;
	wire [7:0] ad = bus_req.addr;
	wire hit_ctrla = ad == `CBS_OFF_CTRLA;
	wire hit_cb_clr = ad == `CBS_OFF_CB_CLR;
	wire hit_cb_set = ad == `CBS_OFF_CB_SET;
	wire hit_int_clr = ad == `CBS_OFF_INT_CLR;
	wire hit_int_en = ad == `CBS_OFF_INT_EN;
	wire hit_int_st = ad == `CBS_OFF_INT_ST;
	wire hit_status = ad == `CBS_OFF_STATUS;
	wire hit_period = ad == `CBS_OFF_PERIOD;
	wire hit_per_buf = ad == `CBS_OFF_PER_BUF;
	wire wr_ctrla = wr && hit_ctrla;
	wire wr_cb_clr = wr && hit_cb_clr;
	wire wr_cb_set = wr && hit_cb_set;
	wire wr_status = wr && hit_status;
	wire wr_per_buf = wr && hit_per_buf;
	wire [2:0] wr_cmd = wd[`CBS_CB_CMD_LSB +: 3];

	// ==========================================
	// Command execution on the prescaled tick
	wire cmd_exec = prescale_tick && (cmd_q != CBS_CMD_NONE);
	wire do_retrig = cmd_exec && (cmd_q == CBS_CMD_RETRIGGER);
	wire do_stop = cmd_exec && (cmd_q == CBS_CMD_STOP);
	wire do_update = cmd_exec && (cmd_q == CBS_CMD_UPDATE);
	wire do_sync = cmd_exec && (cmd_q == CBS_CMD_COUNT_SYNC);
	wire cmd_load = wr_cb_set && (wr_cmd != 3'h0);

	// Update condition: wrap while running and unlocked, or forced
	wire upd_hw = wrap_event && counter_run_q && !lock_q;
	wire upd = upd_hw || do_update;
	wire mode8 = mode_q == CBS_MODE_8;
	wire lock_clr_wr = wr_status && lock_q;

	// ==========================================
	// Run state: every stop condition wins over a start
	wire halt_single = wrap_event && single_q && counter_run_q;
	wire start = do_retrig || (en_q && !en_prev_q);
	always_comb begin
		stop_d = stop_q;
		if (start)
			stop_d = 1'b0;
		if (!en_q || do_stop || halt_single)
			stop_d = 1'b1;
	end

	// ==========================================
	// Period buffer valid
	wire per_set = wr_per_buf && mode8;
	wire per_clr = (lock_clr_wr && wd[`CBS_ST_PERV]) || upd;
	assign per_valid_d = per_set || (per_valid_q && !per_clr);

	// ==========================================
	// Channel buffers, one slice per channel
	wire [NUM_CH-1:0] ch_hit_val;
	wire [NUM_CH-1:0] ch_hit_buf;
	wire [NUM_CH-1:0] ch_set;
	wire [NUM_CH-1:0] ch_clr;
	wire [NUM_CH:0][7:0] ch_rd_acc;
	assign ch_rd_acc[0] = 8'h00;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			wire [7:0] off_val = `CBS_OFF_CH_VAL + 8'(gi);
			wire [7:0] off_buf = `CBS_OFF_CH_BUF + 8'(gi);
			wire cap = cap_mode_q[gi];
			wire st_bit = wd[`CBS_ST_CHV_LSB + gi];
			assign ch_hit_val[gi] = ad == off_val;
			assign ch_hit_buf[gi] = ad == off_buf;
			// Compare: buffer write; capture: landed value
			assign ch_set[gi] = cap ? capture_strobe[gi]
				: (wr && ch_hit_buf[gi]);
			// Capture clears on read, compare on update
			assign ch_clr[gi] = cap ? (rd && ch_hit_val[gi])
				: ((lock_clr_wr && st_bit) || upd);
			assign ch_rd_acc[gi+1] = ch_rd_acc[gi]
				| (ch_hit_val[gi] ? channel_value_q[gi] : 8'h00)
				| (ch_hit_buf[gi] ? ch_buf_q[gi] : 8'h00);
			// Buffer load and copy into the active value
			always_ff @(posedge clk) begin
				if (rst) begin
					ch_buf_q[gi] <= `CBS_RST_BYTE;
					channel_value_q[gi] <= `CBS_RST_BYTE;
					ch_valid_q[gi] <= `CBS_RST_BIT;
				end else begin
					if (ch_set[gi])
						ch_buf_q[gi] <= cap ? capture_value : wd;
					if (upd && ch_valid_q[gi])
						channel_value_q[gi] <= ch_buf_q[gi];
					ch_valid_q[gi] <= ch_set[gi]
						|| (ch_valid_q[gi] && !ch_clr[gi]);
				end
			end
		end
	endgenerate

	// ==========================================
	// Interrupt status and level
	wire [3:0] int_ev;
	assign int_ev[`CBS_INT_WRAP] = wrap_event;
	assign int_ev[`CBS_INT_STOP] = stop_d && !stop_q;
	assign int_ev[`CBS_INT_UPD] = upd;
	assign int_ev[`CBS_INT_CAP] = |(capture_strobe & cap_mode_q);
	wire [3:0] int_clr = (wr && hit_int_clr) ? wd[3:0] : 4'h0;
	assign int_st_d = int_ev | (int_st_q & ~int_clr);

	// ==========================================
	// Read data selection
	wire [7:0] ctrla_rd = {2'h0, 2'(cap_mode_q), mode_q, en_q, 1'b0};
	wire [7:0] cb_rd = {cmd_q, 2'h0, single_q, lock_q, dir_q};
	wire [7:0] ch_bits = 8'(ch_valid_q) << `CBS_ST_CHV_LSB;
	wire per_rd = per_valid_q && mode8;
	wire [7:0] status_rd = ch_bits
		| {4'h0, per_rd, 1'b0, pair_q, stop_q};
	wire [7:0] rd_mux = ({8{hit_ctrla}} & ctrla_rd)
		| ({8{hit_cb_clr || hit_cb_set}} & cb_rd)
		| ({8{hit_int_en}} & {4'h0, int_en_q})
		| ({8{hit_int_st}} & {4'h0, int_st_q})
		| ({8{hit_status}} & status_rd)
		| ({8{hit_period}} & period_q)
		| ({8{hit_per_buf}} & per_buf_q)
		| ch_rd_acc[NUM_CH];

	// ==========================================
	// Control A fields
	always_ff @(posedge clk) begin
		if (rst) begin
			en_q <= `CBS_RST_BIT;
			en_prev_q <= `CBS_RST_BIT;
			mode_q <= CBS_MODE_16;
			cap_mode_q <= '0;
		end else begin
			en_prev_q <= en_q;
			if (wr_ctrla) begin
				en_q <= wd[`CBS_CTRLA_EN];
				mode_q <= cbs_mode_type'(wd[`CBS_CTRLA_MODE_LSB +: 2]);
				cap_mode_q <= wd[`CBS_CTRLA_CAP_LSB +: NUM_CH];
			end
		end
	end

	// Control B: set and clear views of one register
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_q <= `CBS_RST_BIT;
			single_q <= `CBS_RST_BIT;
			dir_q <= `CBS_RST_BIT;
		end else if (wr_cb_set) begin
			lock_q <= lock_q || wd[`CBS_CB_LOCK];
			single_q <= single_q || wd[`CBS_CB_SINGLE];
			dir_q <= dir_q || wd[`CBS_CB_DIR];
		end else if (wr_cb_clr) begin
			lock_q <= lock_q && !wd[`CBS_CB_LOCK];
			single_q <= single_q && !wd[`CBS_CB_SINGLE];
			dir_q <= dir_q && !wd[`CBS_CB_DIR];
		end
	end

	// Command field: held until the tick, then reads zero
	always_ff @(posedge clk) begin
		if (rst)
			cmd_q <= CBS_CMD_NONE;
		else if (cmd_load)
			cmd_q <= cbs_cmd_type'(wr_cmd);
		else if (cmd_exec)
			cmd_q <= CBS_CMD_NONE;
	end

	// Command pulses and run state
	always_ff @(posedge clk) begin
		if (rst) begin
			retrigger_q <= `CBS_RST_BIT;
			read_sync_q <= `CBS_RST_BIT;
			stop_q <= `CBS_RST_STOP;
			counter_run_q <= `CBS_RST_BIT;
			pair_q <= `CBS_RST_BIT;
		end else begin
			retrigger_q <= do_retrig && en_q;
			read_sync_q <= do_sync;
			stop_q <= stop_d;
			counter_run_q <= !stop_d;
			pair_q <= IS_ODD && master_is_32bit;
		end
	end

	// Period buffer and its copy
	always_ff @(posedge clk) begin
		if (rst) begin
			per_buf_q <= `CBS_RST_BYTE;
			period_q <= `CBS_RST_BYTE;
			per_valid_q <= `CBS_RST_BIT;
		end else begin
			if (wr_per_buf)
				per_buf_q <= wd;
			if (upd && per_valid_q)
				period_q <= per_buf_q;
			per_valid_q <= per_valid_d;
		end
	end

	// Interrupt registers and read port
	always_ff @(posedge clk) begin
		if (rst) begin
			int_st_q <= 4'h0;
			int_en_q <= 4'h0;
			irq_q <= `CBS_RST_BIT;
			rd_data_q <= `CBS_RST_BYTE;
		end else begin
			int_st_q <= int_st_d;
			if (wr && hit_int_en)
				int_en_q <= wd[3:0];
			irq_q <= |(int_st_q & int_en_q);
			rd_data_q <= rd ? rd_mux : 8'h00;
		end
	end

	assign count_dir_q = dir_q;

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Steps of a stop command
	sequence s_stop_issued;
		wr_cb_set && (wr_cmd == 3'h2);
	endsequence
	sequence s_stop_run;
		prescale_tick && !wr && (cmd_q == CBS_CMD_STOP);
	endsequence

	AST_LOCK_BLOCKS: assert property (
		lock_q && !do_update |=> $stable(period_q)
			&& $stable(channel_value_q))
		else $error("Copy happened while locked");
	AST_LOCK_SET: assert property (
		wr_cb_set && wd[`CBS_CB_LOCK] |=> lock_q)
		else $error("Lock not set by write of one");
	AST_LOCK_ZERO: assert property (
		wr_cb_set && !wd[`CBS_CB_LOCK] |=> $stable(lock_q))
		else $error("Lock changed by write of zero");
	AST_STOP_DIS: assert property (
		!en_q |=> stop_q && !counter_run_q)
		else $error("Not stopped while disabled");
	AST_STOP_CMD: assert property (
		s_stop_issued ##[1:2] s_stop_run |=> stop_q
			&& cmd_q == CBS_CMD_NONE)
		else $error("Stop command not executed");
	AST_SINGLE: assert property (
		halt_single |=> stop_q ##1 stop_q || $past(start))
		else $error("Single run did not halt");
	AST_CONT: assert property (
		wrap_event && counter_run_q && !single_q && en_q
			&& !cmd_exec |=> counter_run_q)
		else $error("Counter halted without single run");
	AST_CMP_SET: assert property (
		wr && ch_hit_buf[0] && !cap_mode_q[0] |=> ch_valid_q[0])
		else $error("Compare valid not set");
	AST_CMP_CLR: assert property (
		lock_clr_wr && wd[`CBS_ST_CHV_LSB] && !cap_mode_q[0]
			&& !ch_set[0] |=> !ch_valid_q[0])
		else $error("Compare valid not cleared");
	AST_CAP: assert property (
		cap_mode_q[NUM_CH-1] && capture_strobe[NUM_CH-1]
			|=> ch_valid_q[NUM_CH-1]
			&& ch_buf_q[NUM_CH-1] == $past(capture_value))
		else $error("Capture not stored");
	AST_CAP_RD: assert property (
		cap_mode_q[NUM_CH-1] && rd && ch_hit_val[NUM_CH-1]
			&& !capture_strobe[NUM_CH-1] |=> !ch_valid_q[NUM_CH-1])
		else $error("Capture valid not cleared by read");
	AST_PER_SET: assert property (
		wr_per_buf && mode8 |=> per_valid_q)
		else $error("Period valid not set");
	AST_PER_ZERO: assert property (
		rd && hit_status && !mode8 |=> !rd_data_q[`CBS_ST_PERV])
		else $error("Period valid visible outside 8-bit");
	AST_PAIR: assert property (
		##1 pair_q == (IS_ODD && $past(master_is_32bit)))
		else $error("Pair flag wrong");
	AST_UPD_COPY: assert property (
		upd && per_valid_q && !per_set |=> !per_valid_q
			&& period_q == $past(per_buf_q))
		else $error("Period not copied on update");
endmodule

/* File: testbench/cbs_top_tb.sv */
// Self-checking bench of the buffer status logic against a behavioural model
module cbs_top_tb import cbs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Stimulus signals and model state
	logic clk, rst, prescale_tick, wrap_event, m32;
	logic [1:0] capture_strobe;
	logic [7:0] capture_value, rd_data_q, period_q;
	logic [1:0][7:0] channel_value_q;
	logic counter_run_q, retrigger_q, read_sync_q, count_dir_q, irq_q;
	cbs_bus_req_type req;
	logic en, stopped, lock, single, dir, perv;
	logic [1:0] mode, cap, chv;
	logic [2:0] cmd;
	logic [7:0] per_a, per_b, intst, inten, v;
	logic [7:0] cha [2];
	logic [7:0] chb [2];
	int err_total, num_checks, seed, exp_retrig, exp_sync, n_retrig, n_sync;
	logic [2:0] cmds [5] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4};

	cbs_top #(.NUM_CH(2), .IS_ODD(1'b1)) dut (
		.clk(clk), .rst(rst), .bus_req(req), .rd_data_q(rd_data_q),
		.prescale_tick(prescale_tick), .wrap_event(wrap_event),
		.capture_strobe(capture_strobe), .capture_value(capture_value),
		.master_is_32bit(m32), .counter_run_q(counter_run_q),
		.retrigger_q(retrigger_q), .read_sync_q(read_sync_q),
		.count_dir_q(count_dir_q), .period_q(period_q),
		.channel_value_q(channel_value_q), .irq_q(irq_q)
	);

	// ==========================================
	// Clock and pulse counters
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (retrigger_q === 1'b1) n_retrig++;
		if (read_sync_q === 1'b1) n_sync++;
	end

	// ==========================================
	// Comparison, verdict and watchdog
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		results();
	end

	// ==========================================
	// Model update shared by the wrap and tick event tasks, and a random byte source
	task automatic upd();
		if (perv) per_a = per_b;
		for (int i = 0; i < 2; i++) if (chv[i]) cha[i] = chb[i];
		perv = 1'b0;
		chv = chv & cap;
		intst[2] = 1'b1;
	endtask
	function automatic logic [7:0] rnd();
		return 8'($random(seed));
	endfunction

	// ==========================================
	// Register port cycles, one strobe cycle each
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
		case (a)
			8'h00: begin
				if (d[1] && !en) stopped = 1'b0;
				if (!d[1] && !stopped) intst[1] = 1'b1;
				if (!d[1]) stopped = 1'b1;
				en = d[1];
				mode = d[3:2];
				cap = d[5:4];
			end
			8'h04: {single, lock, dir} = {single, lock, dir} & ~d[2:0];
			8'h05: begin
				{single, lock, dir} = {single, lock, dir} | d[2:0];
				if (d[7:5] != 3'h0) cmd = d[7:5];
			end
			8'h08: intst = intst & ~d;
			8'h09: inten = d;
			8'h0B: if (lock) begin
				perv = perv & ~d[3];
				chv = chv & ~(d[5:4] & ~cap);
			end
			8'h1B: begin
				per_b = d;
				if (mode == 2'h1) perv = 1'b1;
			end
			8'h30, 8'h31: begin
				chb[a[0]] = d;
				if (!cap[a[0]]) chv[a[0]] = 1'b1;
			end
			default: ;
		endcase
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 d = rd_data_q;
		if (a[7:4] == 4'h2 && cap[a[0]]) chv[a[0]] = 1'b0;
	endtask

	// ==========================================
	// Core event pulses
	task automatic wrap();
		@(posedge clk);
		wrap_event <= 1'b1;
		@(posedge clk);
		wrap_event <= 1'b0;
		intst[0] = 1'b1;
		if (!stopped) begin
			if (!lock) upd();
			if (single) begin
				stopped = 1'b1;
				intst[1] = 1'b1;
			end
		end
	endtask
	task automatic tick();
		@(posedge clk);
		prescale_tick <= 1'b1;
		@(posedge clk);
		prescale_tick <= 1'b0;
		case (cmd)
			3'h1: if (en) begin
				stopped = 1'b0;
				exp_retrig++;
			end
			3'h2: begin
				if (!stopped) intst[1] = 1'b1;
				stopped = 1'b1;
			end
			3'h3: upd();
			3'h4: exp_sync++;
			default: ;
		endcase
		cmd = 3'h0;
	endtask
	task automatic capture(input logic [7:0] d);
		@(posedge clk);
		capture_strobe <= 2'b10;
		capture_value <= d;
		@(posedge clk);
		capture_strobe <= 2'b00;
		chb[1] = d;
		chv[1] = 1'b1;
		if (cap[1]) intst[3] = 1'b1;
	endtask

	// ==========================================
	// Compare status, control B, interrupt status and the level outputs with the model
	task automatic check_all();
		logic [7:0] r;
		logic [7:0] e;
		rd(8'h0B, r);
		e = {2'b00, chv, perv && mode == 2'h1, 1'b0, m32, stopped};
		chk("status", r, e);
		rd(8'h05, r);
		chk("control_b", r, {cmd, 2'b00, single, lock, dir});
		rd(8'h0A, r);
		chk("int_status", r, intst);
		chk("run", counter_run_q, !stopped);
		chk("dir", count_dir_q, dir);
		chk("period", period_q, per_a);
		chk("chan0", channel_value_q[0], cha[0]);
		chk("chan1", channel_value_q[1], cha[1]);
		chk("irq", irq_q, |(intst & inten));
	endtask

	// ==========================================
	// Main sequence
	initial begin
		{rst, prescale_tick, wrap_event, m32} = 4'b1000;
		{capture_strobe, capture_value, req} = '0;
		{en, lock, single, dir, perv, mode, cap, chv, cmd} = '0;
		{per_a, per_b, intst, inten} = '0;
		cha = '{8'h00, 8'h00};
		chb = '{8'h00, 8'h00};
		stopped = 1'b1;
		seed = 34;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		check_all();
		rd(8'h7F, v);
		chk("unmapped", v, 8'h00);
		wr(8'h00, 8'h06);
		wr(8'h05, 8'h00);
		check_all();
		wr(8'h05, 8'h02);
		wr(8'h1B, rnd());
		wr(8'h30, rnd());
		wr(8'h31, rnd());
		check_all();
		wrap();
		check_all();
		wr(8'h0B, 8'h18);
		check_all();
		wr(8'h04, 8'h02);
		wr(8'h1B, rnd());
		wr(8'h09, 8'h04);
		wr(8'h0B, 8'h08);
		check_all();
		wrap();
		check_all();
		wr(8'h08, 8'hFF);
		wr(8'h09, 8'h00);
		wr(8'h1B, rnd());
		wr(8'h00, 8'h02);
		check_all();
		wr(8'h00, 8'h0A);
		check_all();
		wr(8'h00, 8'h06);
		m32 <= 1'b1;
		check_all();
		m32 <= 1'b0;
		wr(8'h05, 8'h02);
		wr(8'h1B, rnd());
		wr(8'h30, rnd());
		for (int i = 0; i < 5; i++) begin
			wr(8'h05, {cmds[i], 5'h01});
			tick();
			check_all();
		end
		chk("retrigger", 8'(n_retrig), 8'(exp_retrig));
		chk("read_sync", 8'(n_sync), 8'(exp_sync));
		wr(8'h04, 8'h02);
		wrap();
		check_all();
		wr(8'h05, 8'h04);
		wrap();
		check_all();
		wr(8'h05, 8'h20);
		rd(8'h05, v);
		chk("cmd_pending", v, {cmd, 2'b00, single, lock, dir});
		tick();
		wr(8'h00, 8'h26);
		capture(rnd());
		check_all();
		rd(8'h21, v);
		chk("chan1_read", v, cha[1]);
		check_all();
		wr(8'h00, 8'h00);
		check_all();
		results();
	end
endmodule
